// ==== src/touch_pkg.sv ====
package touch_pkg;

  // ----------------------------------------------------------------
  // arithmetic width and clock
  // ----------------------------------------------------------------
  localparam int SIG_W = 16;
  localparam int CLK_MHZ = 100;
  localparam int CLK_PERIOD_NS = 10;

  // ----------------------------------------------------------------
  // timing, in printed units, and derived cycle counts
  // ----------------------------------------------------------------
  localparam int BURST_MS = 75;
  localparam int CONFIRM_MS = 18;
  localparam int PULSE_MS = 75;
  localparam int TONE_MS = 75;
  localparam int HEALTH_US = 350;
  localparam int TONE_HZ = 4000;
  localparam int SHORT_LIMIT_S = 10;
  localparam int LONG_LIMIT_S = 60;
  localparam int DISCHARGE_NS = 1000;

  localparam int BURST_CYC = BURST_MS * 1000 * CLK_MHZ;
  localparam int CONFIRM_CYC = CONFIRM_MS * 1000 * CLK_MHZ;
  localparam int PULSE_CYC = PULSE_MS * 1000 * CLK_MHZ;
  localparam int TONE_CYC = TONE_MS * 1000 * CLK_MHZ;
  localparam int HEALTH_CYC = HEALTH_US * CLK_MHZ;
  localparam int TONE_HALF_CYC = (CLK_MHZ * 1000000) / (2 * TONE_HZ);
  localparam int DISCHARGE_CYC = DISCHARGE_NS / CLK_PERIOD_NS;
  // limits counted in bursts, so no product overflows 32 bits
  localparam int SHORT_LIMIT_BURSTS = (SHORT_LIMIT_S * 1000) / BURST_MS;
  localparam int LONG_LIMIT_BURSTS = (LONG_LIMIT_S * 1000) / BURST_MS;

  // ----------------------------------------------------------------
  // detection constants
  // ----------------------------------------------------------------
  localparam logic [2:0] INTEG_COUNT = 3'h4;
  localparam logic [15:0] THR_HIGH = 16'h000A;
  localparam logic [15:0] THR_MED = 16'h0014;
  localparam logic [15:0] THR_LOW = 16'h0028;
  localparam int HYST_PCT = 17;
  localparam logic [15:0] DRIFT_UP_STEP = 16'h0001;
  localparam logic [15:0] DRIFT_DOWN_STEP = 16'h0008;
  localparam logic [7:0] DRIFT_UP_DIV = 8'h10;

  typedef enum logic [2:0] {
    MODE_DC10 = 3'b001,
    MODE_DC60 = 3'b010,
    MODE_TOGGLE = 3'b011,
    MODE_PULSE = 3'b100
  } out_mode_e;

  typedef enum logic [1:0] {
    GAIN_HIGH = 2'h0,
    GAIN_MED = 2'h1,
    GAIN_LOW = 2'h2
  } gain_e;

  typedef enum logic [3:0] {
    ST_STRAP = 4'b0001,
    ST_IDLE = 4'b0010,
    ST_HEALTH = 4'b0100,
    ST_BURST = 4'b1000
  } seq_e;

  typedef struct packed {
    logic out_o;
    logic out_oe;
  } out_pin_s;

  typedef struct packed {
    logic a_o;
    logic a_oe;
    logic b_o;
    logic b_oe;
  } sense_drive_s;

endpackage

// ==== src/touch_countdown.sv ====
`timescale 1ns/1ns
// loadable down counter; done pulses the cycle it reaches zero
module touch_countdown
  import touch_pkg::*;
#(
  parameter int W = 32
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // status
  output logic busy,
  output logic done
);

  logic [W-1:0] cnt_r;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      done <= 1'b0;
    end else begin
      done <= !load && (cnt_r == W'(1));
    end
  end

  assign busy = (cnt_r != '0);

endmodule

// ==== src/touch_detect_output_logic.sv ====
`timescale 1ns/1ns
// Contract
// - signal arithmetic in sixteen bits, hysteresis product in 32
// - reference slews toward signal when idle
// - reference frozen while detection holds
// - downward tracking faster than upward
// - threshold is reference plus gain offset
// - release 17 percent of gain offset below threshold
// - on-duration timeout forces full recalibration
// - straps select mode and time limit
// - four consecutive detect bursts activate output
// - bursts every 75ms, confirmations 18ms
// - recalibration at power-up and on on-duration timeout
// - straps sampled once after reset
// - dc mode follows detection, low after timeout
// - toggle inverts per detection, timeout keeps
// - pulse mode gives 75ms high pulse
// - output tristated 350us before each burst
// - output driven low or high otherwise
// - piezo tone 75ms after new detection
// - tone is complementary 4kHz bridge drive
// - sense pins discharged at burst start
// - three gain levels detected at power-up
module touch_detect_output_logic
  import touch_pkg::*;
#(
  parameter int BURST_CYCLES = BURST_CYC,
  parameter int CONFIRM_CYCLES = CONFIRM_CYC,
  parameter int PULSE_CYCLES = PULSE_CYC,
  parameter int TONE_CYCLES = TONE_CYC,
  parameter int HEALTH_CYCLES = HEALTH_CYC,
  parameter int TONE_HALF_CYCLES = TONE_HALF_CYC,
  parameter int DISCHARGE_CYCLES = DISCHARGE_CYC,
  parameter int SHORT_LIMIT = SHORT_LIMIT_BURSTS,
  parameter int LONG_LIMIT = LONG_LIMIT_BURSTS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // straps, asynchronous pins
  input wire logic option_strap_a,
  input wire logic option_strap_b,
  input wire logic gain_tied_strap_a,
  input wire logic gain_tied_output,
  // acquisition front end
  input wire logic sample_valid,
  input wire logic [SIG_W-1:0] sample_data,
  output logic burst_start,
  // output pin
  output logic out_o,
  output logic out_oe,
  // sense pins
  output logic sense_pin_a_o,
  output logic sense_pin_a_oe,
  output logic sense_pin_b_o,
  output logic sense_pin_b_oe,
  // status
  output logic detect_active
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] strap_s1_r;
  logic [3:0] strap_s2_r;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      strap_s1_r <= 4'h0;
      strap_s2_r <= 4'h0;
    end else begin
      strap_s1_r <= {option_strap_a, option_strap_b,
                     gain_tied_strap_a, gain_tied_output};
      strap_s2_r <= strap_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // sequencer: strap capture, health window, burst
  // ----------------------------------------------------------------
  seq_e seq_r;
  out_mode_e mode_r;
  gain_e gain_r;
  logic [1:0] strap_wait_r;
  logic timer_load;
  logic [31:0] timer_val;
  logic timer_busy;
  logic timer_done;
  logic fast_r;

  // the second sync stage is valid two edges after release
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      strap_wait_r <= 2'h0;
    end else if (strap_wait_r != 2'h3) begin
      strap_wait_r <= strap_wait_r + 2'h1;
    end
  end

  // straps read once; no later input reaches mode or gain
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mode_r <= MODE_TOGGLE;
      gain_r <= GAIN_HIGH;
    end else if (seq_r == ST_STRAP && strap_wait_r == 2'h3) begin
      case (strap_s2_r[3:2])
        2'b11: mode_r <= MODE_DC10;
        2'b10: mode_r <= MODE_DC60;
        2'b00: mode_r <= MODE_TOGGLE;
        default: mode_r <= MODE_PULSE;
      endcase
      if (strap_s2_r[0]) begin
        gain_r <= GAIN_LOW;
      end else if (strap_s2_r[1]) begin
        gain_r <= GAIN_MED;
      end else begin
        gain_r <= GAIN_HIGH;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      seq_r <= ST_STRAP;
    end else begin
      case (seq_r)
        ST_STRAP: if (strap_wait_r == 2'h3) seq_r <= ST_IDLE;
        ST_IDLE: if (timer_done) seq_r <= ST_HEALTH;
        ST_HEALTH: if (timer_done) seq_r <= ST_BURST;
        ST_BURST: if (sample_valid) seq_r <= ST_IDLE;
        default: seq_r <= ST_STRAP;
      endcase
    end
  end

  // idle gap shortened during confirmation, health window subtracted
  always_comb begin
    timer_load = 1'b0;
    timer_val = 32'h0000_0000;
    if (seq_r == ST_STRAP && strap_wait_r == 2'h3) begin
      timer_load = 1'b1;
      timer_val = 32'(BURST_CYCLES - HEALTH_CYCLES);
    end else if (seq_r == ST_IDLE && timer_done) begin
      timer_load = 1'b1;
      timer_val = 32'(HEALTH_CYCLES);
    end else if (seq_r == ST_BURST && sample_valid) begin
      timer_load = 1'b1;
      timer_val = fast_r ? 32'(CONFIRM_CYCLES - HEALTH_CYCLES)
                         : 32'(BURST_CYCLES - HEALTH_CYCLES);
    end
  end

  touch_countdown #(.W(32)) u_seq_timer (
    .core_clk(core_clk),
    .resetn(resetn),
    .load(timer_load),
    .load_val(timer_val),
    .busy(timer_busy),
    .done(timer_done)
  );

  // ----------------------------------------------------------------
  // reference, threshold, hysteresis
  // ----------------------------------------------------------------
  logic [SIG_W-1:0] ref_r;
  logic calibrated_r;
  logic [SIG_W-1:0] offset;
  logic [SIG_W-1:0] thresh;
  logic [SIG_W-1:0] release_lvl;
  logic [SIG_W-1:0] hyst;
  logic [7:0] up_div_r;
  logic raw_det;
  logic state_r;
  logic [2:0] integ_r;
  logic recal;
  logic take;

  assign take = (seq_r == ST_BURST) && sample_valid;

  always_comb begin
    case (gain_r)
      GAIN_HIGH: offset = THR_HIGH;
      GAIN_MED: offset = THR_MED;
      default: offset = THR_LOW;
    endcase
  end

  // 17 percent via a 32 by 32 product, then truncated back to 16 bits
  assign hyst = 16'((32'(offset) * 32'(HYST_PCT)) / 32'd100);
  assign thresh = ref_r + offset;
  assign release_lvl = thresh - hyst;
  assign raw_det = state_r ? (sample_data >= release_lvl)
                           : (sample_data >= thresh);

  // first burst after reset and the on-duration timeout recalibrate
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ref_r <= 16'h0000;
      calibrated_r <= 1'b0;
      up_div_r <= 8'h00;
    end else if (take) begin
      if (!calibrated_r || recal) begin
        ref_r <= sample_data;
        calibrated_r <= 1'b1;
        up_div_r <= 8'h00;
      end else if (!state_r && integ_r == 3'h0) begin
        if (sample_data < ref_r) begin
          ref_r <= (ref_r - sample_data > DRIFT_DOWN_STEP) ?
                   ref_r - DRIFT_DOWN_STEP : sample_data;
        end else if (sample_data > ref_r) begin
          if (up_div_r == DRIFT_UP_DIV - 8'h01) begin
            up_div_r <= 8'h00;
            ref_r <= ref_r + DRIFT_UP_STEP;
          end else begin
            up_div_r <= up_div_r + 8'h01;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // integrator and detection state
  // ----------------------------------------------------------------
  logic [15:0] dur_r;
  logic [15:0] limit;
  logic new_det;

  assign limit = (mode_r == MODE_DC60) ? 16'(LONG_LIMIT)
                                       : 16'(SHORT_LIMIT);
  assign recal = state_r && (dur_r >= limit);
  assign new_det = take && calibrated_r && !recal && !state_r &&
                   raw_det && (integ_r == INTEG_COUNT - 3'h1);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      integ_r <= 3'h0;
      state_r <= 1'b0;
      fast_r <= 1'b0;
    end else if (take) begin
      if (!calibrated_r || recal) begin
        integ_r <= 3'h0;
        state_r <= 1'b0;
        fast_r <= 1'b0;
      end else if (state_r) begin
        state_r <= raw_det;
        fast_r <= 1'b0;
      end else if (raw_det) begin
        if (integ_r == INTEG_COUNT - 3'h1) begin
          state_r <= 1'b1;
          integ_r <= 3'h0;
          fast_r <= 1'b0;
        end else begin
          integ_r <= integ_r + 3'h1;
          fast_r <= 1'b1;
        end
      end else begin
        integ_r <= 3'h0;
        fast_r <= 1'b0;
      end
    end
  end

  // duration counted in bursts of detection
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dur_r <= 16'h0000;
    end else if (take) begin
      if (!state_r || recal) begin
        dur_r <= 16'h0000;
      end else begin
        dur_r <= dur_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // output level by mode
  // ----------------------------------------------------------------
  logic level_r;
  logic pulse_busy;

  touch_countdown #(.W(32)) u_pulse_timer (
    .core_clk(core_clk),
    .resetn(resetn),
    .load(new_det && mode_r == MODE_PULSE),
    .load_val(32'(PULSE_CYCLES)),
    .busy(pulse_busy),
    .done()
  );

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      level_r <= 1'b0;
    end else begin
      case (mode_r)
        MODE_DC10, MODE_DC60: begin
          if (take) level_r <= !recal && (state_r ?
                               raw_det : new_det);
        end
        MODE_TOGGLE: if (new_det) level_r <= !level_r;
        MODE_PULSE: level_r <= pulse_busy || new_det;
        default: level_r <= 1'b0;
      endcase
    end
  end

  // active drive except during the pre-burst health window
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      out_o <= 1'b0;
      out_oe <= 1'b1;
    end else begin
      out_o <= level_r;
      out_oe <= !(seq_r == ST_HEALTH && timer_busy);
    end
  end

  // ----------------------------------------------------------------
  // piezo tone and sense discharge
  // ----------------------------------------------------------------
  logic tone_busy;
  logic half_done;
  logic phase_r;
  logic dis_busy;

  touch_countdown #(.W(32)) u_tone_timer (
    .core_clk(core_clk),
    .resetn(resetn),
    .load(new_det),
    .load_val(32'(TONE_CYCLES)),
    .busy(tone_busy),
    .done()
  );

  // half-period restarts itself while the tone runs
  touch_countdown #(.W(32)) u_half_timer (
    .core_clk(core_clk),
    .resetn(resetn),
    .load(new_det || (half_done && tone_busy)),
    .load_val(32'(TONE_HALF_CYCLES)),
    .busy(),
    .done(half_done)
  );

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      phase_r <= 1'b0;
    end else if (new_det) begin
      phase_r <= 1'b0;
    end else if (half_done && tone_busy) begin
      phase_r <= !phase_r;
    end
  end

  touch_countdown #(.W(32)) u_dis_timer (
    .core_clk(core_clk),
    .resetn(resetn),
    .load(seq_r == ST_HEALTH && timer_done),
    .load_val(32'(DISCHARGE_CYCLES)),
    .busy(dis_busy),
    .done()
  );

  // discharge pulls both pins low; tone drives them in antiphase
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sense_pin_a_o <= 1'b0;
      sense_pin_b_o <= 1'b0;
      sense_pin_a_oe <= 1'b0;
      sense_pin_b_oe <= 1'b0;
    end else if (dis_busy) begin
      sense_pin_a_o <= 1'b0;
      sense_pin_b_o <= 1'b0;
      sense_pin_a_oe <= 1'b1;
      sense_pin_b_oe <= 1'b1;
    end else if (tone_busy && seq_r != ST_BURST) begin
      sense_pin_a_o <= phase_r;
      sense_pin_b_o <= !phase_r;
      sense_pin_a_oe <= 1'b1;
      sense_pin_b_oe <= 1'b1;
    end else begin
      sense_pin_a_o <= 1'b0;
      sense_pin_b_o <= 1'b0;
      sense_pin_a_oe <= 1'b0;
      sense_pin_b_oe <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      burst_start <= 1'b0;
      detect_active <= 1'b0;
    end else begin
      burst_start <= (seq_r == ST_HEALTH) && timer_done;
      detect_active <= state_r;
    end
  end

endmodule

// ==== verification/touch_detect_properties.sv ====
`timescale 1ns/1ns
module touch_detect_properties
  import touch_pkg::*;
#(
  parameter int HEALTH_CYCLES = HEALTH_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // straps
  input wire logic option_strap_a,
  input wire logic option_strap_b,
  input wire logic gain_tied_strap_a,
  input wire logic gain_tied_output,
  // front end
  input wire logic sample_valid,
  input wire logic [SIG_W-1:0] sample_data,
  input wire logic burst_start,
  // pins and status
  input wire logic out_o,
  input wire logic out_oe,
  input wire logic sense_pin_a_o,
  input wire logic sense_pin_a_oe,
  input wire logic sense_pin_b_o,
  input wire logic sense_pin_b_oe,
  input wire logic detect_active
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  // length of the current tristate window
  int low_cnt_r;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      low_cnt_r <= 0;
    end else if (!out_oe) begin
      low_cnt_r <= low_cnt_r + 1;
    end else begin
      low_cnt_r <= 0;
    end
  end

  sequence discharge_s;
    sense_pin_a_oe && sense_pin_b_oe && !sense_pin_a_o && !sense_pin_b_o;
  endsequence
  sequence tone_s;
    sense_pin_a_oe && sense_pin_b_oe && (sense_pin_a_o != sense_pin_b_o);
  endsequence

  health_low_a: assert property (
    $fell(out_oe) |-> !out_oe [*8]) else $error("health window short");
  health_burst_a: assert property (
    burst_start |-> !$past(out_oe)) else $error("burst without health");
  health_len_a: assert property (
    $rose(out_oe) |-> low_cnt_r >= HEALTH_CYCLES
      && low_cnt_r <= HEALTH_CYCLES + 1) else $error("health length");
  sense_discharge_a: assert property (
    burst_start |-> ##[0:1] discharge_s) else $error("no discharge");
  tone_start_a: assert property (
    $rose(detect_active) |-> ##[0:8] tone_s) else $error("no tone");
  tone_anti_a: assert property (
    sense_pin_a_oe && sense_pin_b_oe && (sense_pin_a_o || sense_pin_b_o)
      |-> sense_pin_a_o != sense_pin_b_o) else $error("tone in phase");
  sense_quiet_a: assert property (
    $rose(sense_pin_a_oe) |-> burst_start || $past(burst_start)
      || detect_active) else $error("sense pins driven idle");
  detect_after_sample_a: assert property (
    $changed(detect_active) |-> $past(sample_valid, 2))
    else $error("detect changed without sample");
endmodule

// ==== verification/front_end_model.sv ====
`timescale 1ns/1ns
module front_end_model
  import touch_pkg::*;
(
  // clock
  input wire logic core_clk,
  // bench control
  input wire logic slow,
  input wire logic [SIG_W-1:0] level,
  // burst handshake
  input wire logic burst_start,
  output logic sample_valid,
  output logic [SIG_W-1:0] sample_data
);
  int wait_r = 0;
  // one sample per burst request, after a short or long conversion
  always @(posedge core_clk) begin
    if (burst_start) begin
      wait_r <= slow ? 12 : 2;
    end else if (wait_r > 0) begin
      wait_r <= wait_r - 1;
    end
    if (wait_r == 1 && !burst_start) begin
      sample_valid <= #1 1'b1;
      sample_data <= #1 level;
    end else begin
      sample_valid <= #1 1'b0;
      // stale data is inverted so a late read cannot pass by luck
      sample_data <= #1 ~sample_data;
    end
  end
endmodule

// ==== verification/touch_detect_output_logic_test.sv ====
`timescale 1ns/1ns
module touch_detect_output_logic_test;
  import touch_pkg::*;
  // shortened timing so every mode fits in a short run
  localparam int BURST = 400;
  localparam int CONFIRM = 100;
  localparam int PULSE = 50;
  localparam int TONE = 60;
  localparam int HEALTH = 10;
  localparam int HALF = 4;
  localparam int DISCH = 5;
  localparam int SHORT_LIM = 3;
  localparam int LONG_LIM = 6;
  logic core_clk = 1'b0;
  logic resetn, option_strap_a, option_strap_b;
  logic gain_tied_strap_a, gain_tied_output, slow;
  logic sample_valid, burst_start, out_o, out_oe, detect_active;
  logic sense_pin_a_o, sense_pin_a_oe, sense_pin_b_o, sense_pin_b_oe;
  logic [SIG_W-1:0] level, sample_data;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;

  always #5 core_clk = ~core_clk;

  touch_detect_output_logic #(.BURST_CYCLES(BURST),
    .CONFIRM_CYCLES(CONFIRM), .PULSE_CYCLES(PULSE), .TONE_CYCLES(TONE),
    .HEALTH_CYCLES(HEALTH), .TONE_HALF_CYCLES(HALF),
    .DISCHARGE_CYCLES(DISCH), .SHORT_LIMIT(SHORT_LIM),
    .LONG_LIMIT(LONG_LIM)) u_touch_detect_output_logic (.core_clk(core_clk),
    .resetn(resetn), .option_strap_a(option_strap_a),
    .option_strap_b(option_strap_b), .gain_tied_strap_a(gain_tied_strap_a),
    .gain_tied_output(gain_tied_output), .sample_valid(sample_valid),
    .sample_data(sample_data), .burst_start(burst_start), .out_o(out_o),
    .out_oe(out_oe), .sense_pin_a_o(sense_pin_a_o),
    .sense_pin_a_oe(sense_pin_a_oe), .sense_pin_b_o(sense_pin_b_o),
    .sense_pin_b_oe(sense_pin_b_oe), .detect_active(detect_active));

  front_end_model u_front_end_model (.core_clk(core_clk), .slow(slow),
    .level(level), .burst_start(burst_start),
    .sample_valid(sample_valid), .sample_data(sample_data));

  // ----------------------------------------------------------------
  // bench tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (err_total == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // straps only count at power-up, so every mode needs a fresh reset
  task automatic power_up(input logic a, b, ga, go);
    resetn = 1'b0;
    option_strap_a = a;
    option_strap_b = b;
    gain_tied_strap_a = ga;
    gain_tied_output = go;
    repeat (12) @(posedge core_clk);
    #1;
    check("out_oe", out_oe, 1'b1);
    check("out_o", out_o, 1'b0);
    resetn = 1'b1;
  endtask

  // n bursts at one level, each returning 3 edges after the sample
  task automatic burst(input logic [15:0] val, input int n);
    int t;
    level = val;
    repeat (n) begin
      t = 0;
      do begin
        @(posedge core_clk);
        #1;
        t++;
      end while (!burst_start && t < 600);
      while (!sample_valid && t < 700) begin
        @(posedge core_clk);
        #1;
        t++;
      end
      repeat (3) @(posedge core_clk);
      #1;
    end
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    slow = 1'b0;
    level = 16'h0000;
    power_up(1'b0, 1'b0, 1'b0, 1'b0);
    burst(16'd1000, 1);
    option_strap_a = 1'b1;
    option_strap_b = 1'b1;
    burst(16'd1010, 3);
    check("detect", detect_active, 1'b0);
    burst(16'd1000, 1);
    burst(16'd1010, 3);
    check("detect", detect_active, 1'b0);
    burst(16'd1010, 1);
    check("detect", detect_active, 1'b1);
    check("out_o", out_o, 1'b1);
    check("out_oe", out_oe, 1'b1);
    burst(16'd1010, 4);
    check("detect", detect_active, 1'b0);
    check("out_o", out_o, 1'b1);
    burst(16'd1020, 4);
    check("out_o", out_o, 1'b0);
    power_up(1'b1, 1'b1, 1'b0, 1'b1);
    burst(16'd1000, 1);
    burst(16'd1039, 4);
    check("detect", detect_active, 1'b0);
    burst(16'd1040, 4);
    check("out_o", out_o, 1'b1);
    burst(16'd1036, 1);
    check("detect", detect_active, 1'b1);
    burst(16'd1032, 1);
    check("out_o", out_o, 1'b0);
    // four to detect, then limit bursts counted, recal on the next one
    burst(16'd1040, 8);
    check("detect", detect_active, 1'b0);
    check("out_o", out_o, 1'b0);
    power_up(1'b1, 1'b0, 1'b1, 1'b0);
    slow = 1'b1;
    burst(16'd1000, 1);
    burst(16'd960, 2);
    burst(16'd1005, 4);
    check("detect", detect_active, 1'b1);
    // one burst past the short limit: only the long limit keeps it high
    burst(16'd1005, 4);
    check("out_o", out_o, 1'b1);
    slow = 1'b0;
    power_up(1'b0, 1'b1, 1'b0, 1'b0);
    burst(16'd1000, 1);
    burst(16'd1010, 4);
    check("out_o", out_o, 1'b1);
    repeat (PULSE - 5) @(posedge core_clk);
    #1;
    check("out_o", out_o, 1'b1);
    repeat (7) @(posedge core_clk);
    #1;
    check("out_o", out_o, 1'b0);
    print_verdict();
  end
endmodule

bind touch_detect_output_logic touch_detect_properties #(
  .HEALTH_CYCLES(HEALTH_CYCLES)) u_touch_detect_properties (
  .core_clk(core_clk), .resetn(resetn), .option_strap_a(option_strap_a),
  .option_strap_b(option_strap_b), .gain_tied_strap_a(gain_tied_strap_a),
  .gain_tied_output(gain_tied_output), .sample_valid(sample_valid),
  .sample_data(sample_data), .burst_start(burst_start), .out_o(out_o),
  .out_oe(out_oe), .sense_pin_a_o(sense_pin_a_o),
  .sense_pin_a_oe(sense_pin_a_oe), .sense_pin_b_o(sense_pin_b_o),
  .sense_pin_b_oe(sense_pin_b_oe), .detect_active(detect_active));
